// ==== rtl/port_pin_io_and_edge_filter.sv ====
// Contract
// - input register reads buffered pin level, outputs included.
// - direction bit 1 makes output, 0 input; bits 7:6 read zero.
// - enabled serial peripheral forces direction; stored bit unchanged.
// - direction register read and written at any time.
// - valid edge: 4 passive samples then 4 active samples.
// - run and wait modes sample filters on bus clock.
// - stop mode samples filters from internal rc oscillator.
// - stop-mode oscillator runs only if count<=4, enabled, flag clear.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "port_filter_regs.svh"
module port_pin_io_and_edge_filter
   import port_filter_pkg::*;
#(
   parameter int PINS = 6
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [PINS-1:0]   pin_in,
   output logic      [PINS-1:0]   pin_out,
   output logic      [PINS-1:0]   pin_oe_n,
   input  wire logic              serial_enable,
   input  wire logic [PINS-1:0]   serial_pin_used,
   input  wire logic [PINS-1:0]   serial_pin_dir,
   input  wire logic              rc_osc_tick,
   output logic                   rc_osc_run,
   output logic                   irq
);
   logic [PINS-1:0]   port_m_input_level;
   logic [PINS-1:0]   port_m_direction;
   logic [PINS-1:0]   port_output_data_reg;
   logic [PINS-1:0]   pin_irq_enable;
   logic [PINS-1:0]   pin_irq_flag;
   logic [PINS-1:0]   irq_mask;
   logic [PINS-1:0]   irq_polarity;
   logic [PINS-1:0]   sovr_en;
   logic [PINS-1:0]   sovr_dir;
   logic              stop_mode;
   logic [PINS-1:0]   next_direction;
   logic [PINS-1:0]   next_output_data;
   logic [PINS-1:0]   next_irq_enable;
   logic [PINS-1:0]   next_irq_flag;
   logic [PINS-1:0]   next_irq_mask;
   logic [PINS-1:0]   next_irq_polarity;
   logic [PINS-1:0]   next_sovr_en;
   logic [PINS-1:0]   next_sovr_dir;
   logic              next_stop_mode;
   logic [31:0]       next_prdata;
   logic              next_pslverr;
   logic              next_pready;
   logic [PINS-1:0]   eff_dir;
   logic [PINS-1:0]   valid_edge;
   logic [PINS-1:0]   count_low;
   logic              sample_tick;
   logic              wr_lo;
   logic              wr_hi;
   logic              access;

   // widen a pin vector into a bus word, upper bits zero
   function automatic logic [31:0] word_of(input logic [PINS-1:0] v);
      word_of = 32'h0000_0000;
      word_of[PINS-1:0] = v;
   endfunction : word_of

   // filter clock source: bus clock in run/wait, rc tick in stop
   assign sample_tick = stop_mode ? rc_osc_tick : 1'b1;

   // one edge filter per pin
   genvar g;
   generate
      for (g = 0; g < PINS; g++)
      begin : gen_filter
         pin_edge_filter u_filter (
            .pclk        (pclk),
            .presetn     (presetn),
            .sample_tick (sample_tick),
            .pin_level   (port_m_input_level[g]),
            .active_high (irq_polarity[g]),
            .valid_edge  (valid_edge[g]),
            .count_low   (count_low[g])
         );
      end
   endgenerate

   // effective direction with serial peripheral override
   always_comb
   begin
      eff_dir = port_m_direction;
      if (serial_enable)
         eff_dir = (port_m_direction & ~sovr_en & ~serial_pin_used)
                   | (serial_pin_dir & (sovr_en | serial_pin_used));
   end

   assign access = psel && penable && pready;
   assign wr_lo  = access && pwrite && pstrb[0];
   assign wr_hi  = access && pwrite && pstrb[1];

   // register file next values and read mux
   always_comb
   begin
      next_direction    = port_m_direction;
      next_output_data  = port_output_data_reg;
      next_irq_enable   = pin_irq_enable;
      next_irq_mask     = irq_mask;
      next_irq_polarity = irq_polarity;
      next_sovr_en      = sovr_en;
      next_sovr_dir     = sovr_dir;
      next_stop_mode    = stop_mode;
      next_irq_flag     = pin_irq_flag;
      next_prdata       = prdata;
      next_pslverr      = 1'b0;
      next_pready       = psel && !penable;
      if (wr_lo && paddr == `OFS_DIRECTION)
         next_direction = pwdata[PINS-1:0];
      else if (wr_lo && paddr == `OFS_OUTPUT_DATA)
         next_output_data = pwdata[PINS-1:0];
      else if (wr_lo && paddr == `OFS_IRQ_ENABLE)
         next_irq_enable = pwdata[PINS-1:0];
      else if (wr_lo && paddr == `OFS_IRQ_FLAG)
         next_irq_flag = pin_irq_flag & ~pwdata[PINS-1:0];
      else if (wr_lo && paddr == `OFS_IRQ_MASK)
         next_irq_mask = pwdata[PINS-1:0];
      else if (wr_lo && paddr == `OFS_IRQ_POLARITY)
         next_irq_polarity = pwdata[PINS-1:0];
      else if (access && pwrite && paddr == `OFS_SERIAL_OVR)
      begin
         if (wr_lo)
            next_sovr_en = pwdata[`SOVR_EN_LSB +: PINS];
         if (wr_hi)
            next_sovr_dir = pwdata[`SOVR_DIR_LSB +: PINS];
      end
      else if (wr_lo && paddr == `OFS_POWER_MODE)
         next_stop_mode = pwdata[`POWER_STOP_BIT];
      // set wins over a clear in the same cycle
      next_irq_flag = next_irq_flag | valid_edge;
      if (psel && !penable && !pwrite)
      begin
         if (paddr == `OFS_INPUT_LEVEL)
            next_prdata = word_of(port_m_input_level);
         else if (paddr == `OFS_DIRECTION)
            next_prdata = word_of(port_m_direction);
         else if (paddr == `OFS_OUTPUT_DATA)
            next_prdata = word_of(port_output_data_reg);
         else if (paddr == `OFS_IRQ_ENABLE)
            next_prdata = word_of(pin_irq_enable);
         else if (paddr == `OFS_IRQ_FLAG)
            next_prdata = word_of(pin_irq_flag);
         else if (paddr == `OFS_IRQ_MASK)
            next_prdata = word_of(irq_mask);
         else if (paddr == `OFS_IRQ_POLARITY)
            next_prdata = word_of(irq_polarity);
         else if (paddr == `OFS_SERIAL_OVR)
            next_prdata = word_of(sovr_en) | (word_of(sovr_dir) << `SOVR_DIR_LSB);
         else if (paddr == `OFS_POWER_MODE)
            next_prdata = {31'h0, stop_mode};
         else
            next_prdata = 32'h0000_0000;
      end
      if (psel && !penable)
         next_pslverr = !(paddr == `OFS_INPUT_LEVEL || paddr == `OFS_DIRECTION
                          || paddr == `OFS_OUTPUT_DATA || paddr == `OFS_IRQ_ENABLE
                          || paddr == `OFS_IRQ_FLAG || paddr == `OFS_IRQ_MASK
                          || paddr == `OFS_IRQ_POLARITY || paddr == `OFS_SERIAL_OVR
                          || paddr == `OFS_POWER_MODE);
      else if (psel && penable && !pready)
         next_pslverr = pslverr;
   end

   // register everything; pins and status sampled each clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_m_input_level   <= '0;
         port_m_direction     <= `RST_DIRECTION;
         port_output_data_reg <= `RST_OUTPUT_DATA;
         pin_irq_enable       <= `RST_IRQ_ENABLE;
         pin_irq_flag         <= '0;
         irq_mask             <= `RST_IRQ_MASK;
         irq_polarity         <= `RST_IRQ_POLARITY;
         sovr_en              <= '0;
         sovr_dir             <= '0;
         stop_mode            <= 1'b0;
         prdata               <= 32'h0000_0000;
         pready               <= 1'b0;
         pslverr              <= 1'b0;
         pin_out              <= '0;
         pin_oe_n             <= '1;
         rc_osc_run           <= 1'b0;
         irq                  <= 1'b0;
      end
      else
      begin
         port_m_input_level   <= pin_in;
         port_m_direction     <= next_direction;
         port_output_data_reg <= next_output_data;
         pin_irq_enable       <= next_irq_enable;
         pin_irq_flag         <= next_irq_flag;
         irq_mask             <= next_irq_mask;
         irq_polarity         <= next_irq_polarity;
         sovr_en              <= next_sovr_en;
         sovr_dir             <= next_sovr_dir;
         stop_mode            <= next_stop_mode;
         prdata               <= next_prdata;
         pready               <= next_pready;
         pslverr              <= next_pslverr;
         pin_out              <= port_output_data_reg;
         pin_oe_n             <= ~eff_dir;
         rc_osc_run           <= stop_mode
                                 && |(count_low & pin_irq_enable & ~pin_irq_flag);
         irq                  <= |(next_irq_flag & pin_irq_enable & irq_mask);
      end
   end
endmodule : port_pin_io_and_edge_filter
`default_nettype wire

// ==== shared/port_filter_regs.svh ====
`ifndef PORT_FILTER_REGS_SVH
`define PORT_FILTER_REGS_SVH
// register byte offsets on the apb bus
`define OFS_INPUT_LEVEL     12'h000
`define OFS_DIRECTION       12'h004
`define OFS_OUTPUT_DATA     12'h008
`define OFS_IRQ_ENABLE      12'h00c
`define OFS_IRQ_FLAG        12'h010
`define OFS_IRQ_MASK        12'h014
`define OFS_IRQ_POLARITY    12'h018
`define OFS_SERIAL_OVR      12'h01c
`define OFS_POWER_MODE      12'h020
// reset values
`define RST_DIRECTION       6'h00
`define RST_OUTPUT_DATA     6'h00
`define RST_IRQ_ENABLE      6'h00
`define RST_IRQ_MASK        6'h00
`define RST_IRQ_POLARITY    6'h00
// power mode field
`define POWER_STOP_BIT      0
// serial override fields: enable in [5:0], forced direction in [13:8]
`define SOVR_EN_LSB         0
`define SOVR_DIR_LSB        8
// filter sample counts
`define FILTER_SAMPLES      4
`define FILTER_CNT_W        3
`endif

// ==== shared/port_filter_pkg.sv ====
package port_filter_pkg;
   // filter phase: waiting for passive run, then for active run
   typedef enum logic [1:0] {seek_passive, seek_active, edge_hit} filter_state_type;
endpackage : port_filter_pkg

// ==== rtl/pin_edge_filter.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "port_filter_regs.svh"
module pin_edge_filter
   import port_filter_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       sample_tick,
   input  wire logic       pin_level,
   input  wire logic       active_high,
   output logic            valid_edge,
   output logic            count_low
);
   filter_state_type            state;
   filter_state_type            next_state;
   logic [`FILTER_CNT_W-1:0]    count;
   logic [`FILTER_CNT_W-1:0]    next_count;
   logic                        is_active;

   // next state of the passive/active run counter
   always_comb
   begin
      is_active  = (pin_level == active_high);
      next_state = state;
      next_count = count;
      if (sample_tick)
      begin
         case (state)
            seek_passive:
            begin
               if (is_active)
                  next_count = '0;
               else if (count == 3'(`FILTER_SAMPLES - 1))
               begin
                  next_state = seek_active;
                  next_count = '0;
               end
               else
                  next_count = count + 3'd1;
            end
            seek_active:
            begin
               // passive samples between the runs are allowed
               if (!is_active)
                  next_count = '0;
               else if (count == 3'(`FILTER_SAMPLES - 1))
               begin
                  next_state = edge_hit;
                  next_count = '0;
               end
               else
                  next_count = count + 3'd1;
            end
            default:
            begin
               next_state = seek_passive;
               next_count = is_active ? 3'd0 : 3'd1;
            end
         endcase
      end
   end

   // register the filter state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state      <= seek_passive;
         count      <= '0;
         valid_edge <= 1'b0;
         count_low  <= 1'b1;
      end
      else
      begin
         state      <= next_state;
         count      <= next_count;
         valid_edge <= sample_tick && (state == seek_active) && is_active
                       && (count == 3'(`FILTER_SAMPLES - 1));
         count_low  <= (next_count <= 3'(`FILTER_SAMPLES));
      end
   end
endmodule : pin_edge_filter
`default_nettype wire

// ==== tb/port_filter_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module port_filter_sva #(parameter int PINS = 6) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic            serial_enable,
   input wire logic [PINS-1:0] serial_pin_used,
   input wire logic [PINS-1:0] serial_pin_dir,
   input wire logic [PINS-1:0] pin_oe_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // bus handshake and read data shape
   a_ready_pulse: assert property (psel && !penable |=> pready)
      else $error("ready missing after setup");
   a_ready_once: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   a_idle_quiet: assert property (!psel |=> !pready && !pslverr)
      else $error("answer without request");
   a_rdata_hold: assert property (!psel |=> $stable(prdata))
      else $error("read data moved while idle");
   a_upper_zero: assert property (pready && !pwrite && paddr != 12'h01c |-> prdata[31:6] == 26'h0)
      else $error("unimplemented bits read nonzero");
   a_unmapped_err: assert property (psel && !penable && paddr > 12'h020 |=> pslverr)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 12'h020 |=> !pslverr)
      else $error("mapped access refused");
   // serial peripheral forces the direction of the pins it uses
   a_serial_force: assert property (serial_enable |=> ((pin_oe_n ^ ~$past(serial_pin_dir)) & $past(serial_pin_used)) == '0)
      else $error("serial direction not forced");
endmodule : port_filter_sva
bind port_pin_io_and_edge_filter port_filter_sva #(.PINS(PINS)) u_port_filter_sva (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .serial_enable, .serial_pin_used, .serial_pin_dir, .pin_oe_n);
`default_nettype wire

// ==== tb/pin_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module pin_partner #(parameter int PINS = 6) (
   input wire logic  [PINS-1:0] pin_out,
   input wire logic  [PINS-1:0] pin_oe_n,
   input wire logic  [PINS-1:0] ext_level,
   input wire logic  [PINS-1:0] short_mask,
   output logic      [PINS-1:0] pin_in
);
   // driven pins show the port, others the circuitry; a short overpowers the port
   assign pin_in = (~pin_oe_n & ~short_mask & pin_out) | ((pin_oe_n | short_mask) & ext_level);
endmodule : pin_partner
`default_nettype wire

// ==== tb/port_pin_io_and_edge_filter_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "port_filter_regs.svh"
`define CHK(v, e, m) begin comparisons++; if ((v) !== (e)) begin fails++; $display("MISMATCH %0t %s", $time, m); end end
module port_pin_io_and_edge_filter_test;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        s_en = 1'h0, tick = 1'h0, err, pready, pslverr, rc_osc_run, irq;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [3:0]  pstrb = 4'hf;
   logic [5:0]  pin_in, pin_out, pin_oe_n, ext = 6'h0, shrt = 6'h0, s_used = 6'h0, s_dir = 6'h0;
   int          fails = 0, comparisons = 0;
   port_pin_io_and_edge_filter #(.PINS(6)) u_port_pin_io_and_edge_filter (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n,
      .serial_enable(s_en), .serial_pin_used(s_used), .serial_pin_dir(s_dir), .rc_osc_tick(tick), .rc_osc_run, .irq);
   pin_partner #(.PINS(6)) u_pin_partner (.pin_out, .pin_oe_n, .ext_level(ext), .short_mask(shrt), .pin_in);
   // clock
   initial
   begin
      forever #4 pclk = ~pclk;
   end
   // one apb transfer, held until ready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 50) fails++;
   endtask : apb
   task rd_chk(input logic [11:0] a, input logic [31:0] e, input string m);
      apb(1'h0, a, 32'h0);
      `CHK(rd, e, m)
   endtask : rd_chk
   task wait_n(input int n);
      repeat (n) @(posedge pclk);
   endtask : wait_n
   task t_reset;
      `CHK(pin_oe_n, 6'h3f, "oe after reset")
      for (int i = 1; i < 9; i++) rd_chk(12'(4 * i), 32'h0, "reset value");
      apb(1'h1, 12'h100, 32'h1);
      `CHK(err, 1'h1, "unmapped write")
      rd_chk(12'h100, 32'h0, "unmapped read");
      `CHK(err, 1'h1, "unmapped read err")
      $display("reset test done");
   endtask : t_reset
   task t_pins;
      ext <= 6'h15;
      wait_n(2);
      rd_chk(`OFS_INPUT_LEVEL, 32'h15, "input levels");
      apb(1'h1, `OFS_OUTPUT_DATA, 32'h2a);
      apb(1'h1, `OFS_DIRECTION, 32'hff);
      rd_chk(`OFS_DIRECTION, 32'h3f, "direction readback");
      `CHK(pin_oe_n, 6'h00, "all outputs")
      `CHK(pin_out, 6'h2a, "driven data")
      rd_chk(`OFS_INPUT_LEVEL, 32'h2a, "driven levels");
      shrt <= 6'h01;
      wait_n(2);
      rd_chk(`OFS_INPUT_LEVEL, 32'h2b, "shorted pin");
      shrt <= 6'h00;
      apb(1'h1, `OFS_DIRECTION, 32'h15);
      wait_n(2);
      `CHK(pin_oe_n, 6'h2a, "mixed directions")
      $display("pin test done");
   endtask : t_pins
   task t_serial;
      s_en <= 1'h1;
      s_used <= 6'h03;
      s_dir <= 6'h02;
      wait_n(3);
      `CHK(pin_oe_n, 6'h29, "serial forced")
      rd_chk(`OFS_DIRECTION, 32'h15, "stored direction");
      s_en <= 1'h0;
      wait_n(3);
      `CHK(pin_oe_n, 6'h2a, "serial released")
      $display("serial test done");
   endtask : t_serial
   task t_edge;
      apb(1'h1, `OFS_DIRECTION, 32'h0);
      apb(1'h1, `OFS_IRQ_POLARITY, 32'h02);
      ext <= 6'h01;
      wait_n(10);
      apb(1'h1, `OFS_IRQ_FLAG, 32'h3f);
      apb(1'h1, `OFS_IRQ_ENABLE, 32'h01);
      apb(1'h1, `OFS_IRQ_MASK, 32'h01);
      ext <= 6'h02;
      wait_n(3);
      ext <= 6'h01;
      wait_n(10);
      rd_chk(`OFS_IRQ_FLAG, 32'h0, "three samples no edge");
      ext <= 6'h02;
      wait_n(12);
      rd_chk(`OFS_IRQ_FLAG, 32'h03, "both edges");
      `CHK(irq, 1'h1, "irq raised")
      apb(1'h1, `OFS_IRQ_FLAG, 32'h01);
      rd_chk(`OFS_IRQ_FLAG, 32'h02, "flag cleared");
      `CHK(irq, 1'h0, "irq dropped")
      apb(1'h1, `OFS_IRQ_ENABLE, 32'h02);
      wait_n(2);
      `CHK(irq, 1'h0, "irq masked")
      apb(1'h1, `OFS_IRQ_MASK, 32'h02);
      wait_n(2);
      `CHK(irq, 1'h1, "irq unmasked")
      $display("edge test done");
   endtask : t_edge
   task t_stop;
      apb(1'h1, `OFS_IRQ_ENABLE, 32'h01);
      ext <= 6'h01;
      wait_n(10);
      apb(1'h1, `OFS_IRQ_FLAG, 32'h3f);
      apb(1'h1, `OFS_POWER_MODE, 32'h01);
      wait_n(3);
      `CHK(rc_osc_run, 1'h1, "oscillator requested")
      ext <= 6'h02;
      wait_n(20);
      rd_chk(`OFS_IRQ_FLAG, 32'h0, "no ticks no edge");
      apb(1'h1, `OFS_DIRECTION, 32'h30);
      rd_chk(`OFS_DIRECTION, 32'h30, "write in stop");
      repeat (8)
      begin
         tick <= 1'h1;
         @(posedge pclk);
         tick <= 1'h0;
         wait_n(2);
      end
      wait_n(4);
      rd_chk(`OFS_IRQ_FLAG, 32'h03, "edges on ticks");
      `CHK(rc_osc_run, 1'h0, "oscillator released")
      apb(1'h1, `OFS_POWER_MODE, 32'h0);
      $display("stop test done");
   endtask : t_stop
   task finish_test;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // main sequence after reset
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      t_reset;
      t_pins;
      t_serial;
      t_edge;
      t_stop;
      finish_test;
   end
   // watchdog
   initial
   begin
      #100000;
      fails++;
      finish_test;
   end
endmodule : port_pin_io_and_edge_filter_test
`default_nettype wire
